/* rtl/lcdi_pkg.sv */
/*
 * Shared constants and types of the display driver's two-wire write target.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package lcdi_pkg;
	localparam logic [5:0] LCDI_ADDR_FIXED = 6'h1c;
	localparam int LCDI_ADDR_HI = 7;
	localparam int LCDI_ADDR_LO = 2;
	localparam int LCDI_SEL_BIT = 1;
	localparam int LCDI_RW_BIT = 0;
	localparam int LCDI_CONT_BIT = 7;
	localparam int LCDI_CNT_W = 4;
	localparam logic [3:0] LCDI_LAST_BIT = 4'h7;
	localparam logic [3:0] LCDI_ACK_BIT = 4'h8;
	localparam logic [3:0] LCDI_CNT_RST = 4'h0;
	localparam int LCDI_PTR_W = 5;
	localparam int LCDI_SUB_W = 2;
	localparam logic [4:0] LCDI_PTR_RST = 5'h00;
	localparam logic [4:0] LCDI_PTR_STEP = 5'h01;
	localparam logic [4:0] LCDI_PTR_LAST = 5'h1f;
	localparam logic [1:0] LCDI_SUB_RST = 2'h0;
	localparam logic [1:0] LCDI_SUB_STEP = 2'h1;
	localparam logic [7:0] LCDI_BYTE_RST = 8'h00;
	localparam int LCDI_NSYNC = 6;
	localparam int LCDI_S_SDA = 0;
	localparam int LCDI_S_SCL = 1;
	localparam int LCDI_S_TGL = 2;
	localparam int LCDI_S_STRAP = 3;
	localparam int LCDI_S_SUBLO = 4;
	localparam int LCDI_S_SUBHI = 5;
	typedef enum {LCDI_IDLE, LCDI_ADDR, LCDI_CMD, LCDI_DATA, LCDI_SKIP}
		lcdi_state_t;
endpackage

/* rtl/lcdi_bit_if.sv */
/*
 * Carries each sampled serial bit from the serial-clock domain to the
 * system-clock domain. The toggle marks a new bit; the value is held
 * until the next rising serial clock edge.
 */
`timescale 1ns/1ps
interface lcdi_bit_if;
	logic bit_val;
	logic bit_tgl;
	modport src (output bit_val, output bit_tgl);
	modport dst (input bit_val, input bit_tgl);
endinterface

/* rtl/lcdi_bit_catch.sv */
/*
 * Serial-clock domain bit sampler: takes the data line on every rising
 * serial clock edge and flips a toggle so the other domain sees the event.
 * Assumes the serial clock may stop between frames.
 */
`timescale 1ns/1ps
module lcdi_bit_catch
	import lcdi_pkg::*;
(
	input wire logic scl_clk, // Serial clock, link domain
	input wire logic rst_n, // Async reset, active low
	input wire logic sda_in, // Data line level
	lcdi_bit_if.src bits // Sampled bit and event toggle
);
	logic val;
	logic tgl;
	logic next_val;
	logic next_tgl;

	always_comb
	begin
		next_val = sda_in;
		next_tgl = ~tgl;
	end

	always_ff @(posedge scl_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			val <= 1'b1;
			tgl <= 1'b0;
		end
		else
		begin
			val <= next_val;
			tgl <= next_tgl;
		end
	end

	assign bits.bit_val = val;
	assign bits.bit_tgl = tgl;
endmodule

/* rtl/lcdi_top.sv */
/*
 * Write-only two-wire target front end of a segment display driver:
 * address match, acknowledge, command/data split, data pointer and
 * subaddress counter. Assumes an outside command decoder loads pointer
 * and counter on CLK, and that the pad merges SDA_OUT/SDA_OE_N.
 */
// What this block does
// - Data stable while clock high; changes are conditions
// - Data falling while clock high is START
// - Data rising while clock high is STOP
// - Eight bits MSB first, then acknowledge clock
// - Acknowledge holds data low through clock high
// - Receive only; drive line just for acknowledge
// - Address is 011100 plus strap bit
// - Address bit 1 must equal strap level
// - Read accesses get no response
// - Strap mismatch ignores transfer until next START
// - Matching devices all acknowledge address byte
// - Continuation flag chains command bytes
// - Selected devices acknowledge every command byte
// - Data bytes written at pointer; pointer advances, counter only on wrap
// - Data acknowledged only on subaddress match
// - Repeated START begins fresh address phase
// - Selection needs address only; data writes also need subaddress
`timescale 1ns/1ps
module lcdi_top
	import lcdi_pkg::*;
(
	input wire logic CLK, // System clock, 250 MHz
	input wire logic RSTN, // Async reset, active low
	input wire logic SCL, // Serial clock from controller
	input wire logic SDA_IN, // Data line level
	output logic SDA_OUT, // Data drive value, always low
	output logic SDA_OE_N, // Data drive enable, low drives
	input wire logic ADDRESS_SELECT_STRAP, // Address bit 1 strap
	input wire logic HW_SUBADDRESS_BIT_LO, // Subaddress strap bit 0
	input wire logic HW_SUBADDRESS_BIT_HI, // Subaddress strap bit 1
	input wire logic PTR_LOAD, // Load data pointer
	input wire logic [LCDI_PTR_W-1:0] PTR_VALUE, // Pointer load value
	input wire logic SUB_LOAD, // Load subaddress counter
	input wire logic [LCDI_SUB_W-1:0] SUB_VALUE, // Counter load value
	output logic CMD_VALID, // Command byte strobe
	output logic [7:0] CMD_BYTE, // Received command byte
	output logic DATA_WE, // Display memory write strobe
	output logic [7:0] DATA_BYTE, // Display data byte
	output logic [LCDI_PTR_W-1:0] DATA_PTR, // Write location
	output logic [LCDI_SUB_W-1:0] DATA_SUBADDR, // Counter at write
	output logic SELECTED // Address matched, transfer open
);
	lcdi_bit_if bits ();
	logic [LCDI_NSYNC-1:0] raw;
	logic [LCDI_NSYNC-1:0] sync1;
	logic [LCDI_NSYNC-1:0] sync2;
	logic sda_d;
	logic scl_d;
	logic tgl_d;
	logic start_det;
	logic stop_det;
	logic scl_fall;
	logic bit_ev;
	logic byte_done;
	logic [7:0] rx_byte;
	logic addr_ok;
	logic sub_match;
	logic [LCDI_SUB_W-1:0] hw_sub;

	lcdi_state_t state;
	lcdi_state_t next_state;
	logic [LCDI_CNT_W-1:0] cnt;
	logic [LCDI_CNT_W-1:0] next_cnt;
	logic [7:0] shift;
	logic [7:0] next_shift;
	logic ack_pend;
	logic next_ack_pend;
	logic ack_on;
	logic next_ack_on;
	logic oe_n;
	logic next_oe_n;
	logic [LCDI_PTR_W-1:0] ptr;
	logic [LCDI_PTR_W-1:0] next_ptr;
	logic [LCDI_SUB_W-1:0] sub;
	logic [LCDI_SUB_W-1:0] next_sub;
	logic cmd_v;
	logic next_cmd_v;
	logic [7:0] cmd_b;
	logic [7:0] next_cmd_b;
	logic we;
	logic next_we;
	logic [7:0] wdata;
	logic [7:0] next_wdata;
	logic [LCDI_PTR_W-1:0] wptr;
	logic [LCDI_PTR_W-1:0] next_wptr;
	logic [LCDI_SUB_W-1:0] wsub;
	logic [LCDI_SUB_W-1:0] next_wsub;

	lcdi_bit_catch u_catch (
		.scl_clk(SCL),
		.rst_n(RSTN),
		.sda_in(SDA_IN),
		.bits(bits)
	);

	assign raw[LCDI_S_SDA] = SDA_IN;
	assign raw[LCDI_S_SCL] = SCL;
	assign raw[LCDI_S_TGL] = bits.bit_tgl;
	assign raw[LCDI_S_STRAP] = ADDRESS_SELECT_STRAP;
	assign raw[LCDI_S_SUBLO] = HW_SUBADDRESS_BIT_LO;
	assign raw[LCDI_S_SUBHI] = HW_SUBADDRESS_BIT_HI;

	// Straps sync too: they are pins, may bounce during power-up
	genvar gi;
	generate
		for (gi = 0; gi < LCDI_NSYNC; gi++)
		begin : g_sync
			always_ff @(posedge CLK or negedge RSTN)
			begin
				if (!RSTN)
				begin
					sync1[gi] <= (gi == LCDI_S_TGL) ? 1'b0 : 1'b1;
					sync2[gi] <= (gi == LCDI_S_TGL) ? 1'b0 : 1'b1;
				end
				else
				begin
					sync1[gi] <= raw[gi];
					sync2[gi] <= sync1[gi];
				end
			end
		end
	endgenerate

	always_ff @(posedge CLK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			sda_d <= 1'b1;
			scl_d <= 1'b1;
			tgl_d <= 1'b0; // Matches sampler reset: no false bit
		end
		else
		begin
			sda_d <= sync2[LCDI_S_SDA];
			scl_d <= sync2[LCDI_S_SCL];
			tgl_d <= sync2[LCDI_S_TGL];
		end
	end

	// Data edge while clock stays high is a condition, not a bit
	assign start_det = scl_d && sync2[LCDI_S_SCL] && sda_d &&
		!sync2[LCDI_S_SDA];
	assign stop_det = scl_d && sync2[LCDI_S_SCL] && !sda_d &&
		sync2[LCDI_S_SDA];
	assign scl_fall = scl_d && !sync2[LCDI_S_SCL];
	// Bit value is stable a full serial period after the toggle flips
	assign bit_ev = tgl_d ^ sync2[LCDI_S_TGL];
	assign byte_done = bit_ev && (cnt == LCDI_LAST_BIT);
	assign rx_byte = {shift[6:0], bits.bit_val};
	assign hw_sub = {sync2[LCDI_S_SUBHI], sync2[LCDI_S_SUBLO]};
	assign addr_ok = (rx_byte[LCDI_ADDR_HI:LCDI_ADDR_LO] == LCDI_ADDR_FIXED)
		&& (rx_byte[LCDI_SEL_BIT] == sync2[LCDI_S_STRAP])
		&& !rx_byte[LCDI_RW_BIT];
	assign sub_match = (hw_sub == sub);

	always_comb
	begin
		next_state = state;
		next_cnt = cnt;
		next_shift = shift;
		next_ack_pend = ack_pend;
		next_ack_on = ack_on;
		next_oe_n = oe_n;
		next_ptr = ptr;
		next_sub = sub;
		next_cmd_v = 1'b0;
		next_cmd_b = cmd_b;
		next_we = 1'b0;
		next_wdata = wdata;
		next_wptr = wptr;
		next_wsub = wsub;
		if (PTR_LOAD)
			next_ptr = PTR_VALUE;
		if (SUB_LOAD)
			next_sub = SUB_VALUE;
		if (start_det || stop_det)
		begin
			next_state = start_det ? LCDI_ADDR : LCDI_IDLE;
			next_cnt = LCDI_CNT_RST;
			next_ack_pend = 1'b0;
			next_ack_on = 1'b0;
			next_oe_n = 1'b1;
		end
		else
		begin
			// Acknowledge window runs falling edge to falling edge
			if (scl_fall && ack_pend)
			begin
				next_oe_n = 1'b0;
				next_ack_on = 1'b1;
				next_ack_pend = 1'b0;
			end
			else if (scl_fall && ack_on)
			begin
				next_oe_n = 1'b1;
				next_ack_on = 1'b0;
			end
			if (bit_ev && state != LCDI_IDLE)
			begin
				if (cnt == LCDI_ACK_BIT)
					next_cnt = LCDI_CNT_RST;
				else
				begin
					next_shift = rx_byte;
					next_cnt = cnt + LCDI_SUB_STEP;
				end
			end
			if (byte_done)
			begin
				case (state)
				LCDI_ADDR:
				begin
					next_state = addr_ok ? LCDI_CMD : LCDI_SKIP;
					next_ack_pend = addr_ok;
				end
				LCDI_CMD:
				begin
					next_ack_pend = 1'b1;
					next_cmd_v = 1'b1;
					next_cmd_b = rx_byte;
					if (!rx_byte[LCDI_CONT_BIT])
						next_state = LCDI_DATA;
				end
				LCDI_DATA:
				begin
					next_ack_pend = sub_match;
					next_we = sub_match;
					next_wdata = rx_byte;
					next_wptr = ptr;
					next_wsub = sub;
					next_ptr = ptr + LCDI_PTR_STEP;
					if (ptr == LCDI_PTR_LAST)
						next_sub = sub + LCDI_SUB_STEP;
				end
				default:
				begin
					next_ack_pend = 1'b0;
				end
				endcase
			end
		end
	end

	always_ff @(posedge CLK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			state <= LCDI_IDLE;
			cnt <= LCDI_CNT_RST;
			shift <= LCDI_BYTE_RST;
			ack_pend <= 1'b0;
			ack_on <= 1'b0;
			oe_n <= 1'b1;
			ptr <= LCDI_PTR_RST;
			sub <= LCDI_SUB_RST;
			cmd_v <= 1'b0;
			cmd_b <= LCDI_BYTE_RST;
			we <= 1'b0;
			wdata <= LCDI_BYTE_RST;
			wptr <= LCDI_PTR_RST;
			wsub <= LCDI_SUB_RST;
			SELECTED <= 1'b0;
			SDA_OUT <= 1'b0;
		end
		else
		begin
			state <= next_state;
			cnt <= next_cnt;
			shift <= next_shift;
			ack_pend <= next_ack_pend;
			ack_on <= next_ack_on;
			oe_n <= next_oe_n;
			ptr <= next_ptr;
			sub <= next_sub;
			cmd_v <= next_cmd_v;
			cmd_b <= next_cmd_b;
			we <= next_we;
			wdata <= next_wdata;
			wptr <= next_wptr;
			wsub <= next_wsub;
			SELECTED <= (next_state == LCDI_CMD) || (next_state == LCDI_DATA);
			SDA_OUT <= 1'b0;
		end
	end

	assign SDA_OE_N = oe_n;
	assign CMD_VALID = cmd_v;
	assign CMD_BYTE = cmd_b;
	assign DATA_WE = we;
	assign DATA_BYTE = wdata;
	assign DATA_PTR = wptr;
	assign DATA_SUBADDR = wsub;

	property p_start;
		@(posedge CLK) disable iff (!RSTN)
		start_det |=> (state == LCDI_ADDR) && (cnt == LCDI_CNT_RST);
	endproperty
	a_start: assert property (p_start)
		else $error("START did not open address phase");

	property p_stop;
		@(posedge CLK) disable iff (!RSTN)
		stop_det && !start_det |=> (state == LCDI_IDLE) && SDA_OE_N;
	endproperty
	a_stop: assert property (p_stop)
		else $error("STOP did not idle and release");

	property p_addr_ack;
		@(posedge CLK) disable iff (!RSTN)
		byte_done && (state == LCDI_ADDR) && addr_ok && !start_det &&
		!stop_det |=> (state == LCDI_CMD) && ack_pend && SELECTED;
	endproperty
	a_addr_ack: assert property (p_addr_ack)
		else $error("Matching address not acknowledged");

	property p_read_nak;
		@(posedge CLK) disable iff (!RSTN)
		byte_done && (state == LCDI_ADDR) && rx_byte[LCDI_RW_BIT]
		|=> !ack_pend && !SELECTED;
	endproperty
	a_read_nak: assert property (p_read_nak)
		else $error("Read access answered");

	property p_skip_quiet;
		@(posedge CLK) disable iff (!RSTN)
		(state == LCDI_SKIP) |-> SDA_OE_N && !DATA_WE && !CMD_VALID;
	endproperty
	a_skip_quiet: assert property (p_skip_quiet)
		else $error("Unselected device took part");

	property p_cmd_end;
		@(posedge CLK) disable iff (!RSTN)
		byte_done && (state == LCDI_CMD) && !start_det && !stop_det
		|=> ack_pend && CMD_VALID && (state == ($past(rx_byte[LCDI_CONT_BIT])
		? LCDI_CMD : LCDI_DATA));
	endproperty
	a_cmd_end: assert property (p_cmd_end)
		else $error("Command byte handling wrong");

	property p_data_write;
		@(posedge CLK) disable iff (!RSTN)
		byte_done && (state == LCDI_DATA) && sub_match && !start_det &&
		!stop_det && !PTR_LOAD |=> DATA_WE && ack_pend &&
		(ptr == DATA_PTR + LCDI_PTR_STEP) && (DATA_BYTE == $past(rx_byte));
	endproperty
	a_data_write: assert property (p_data_write)
		else $error("Data write or pointer advance wrong");

	property p_data_nak;
		@(posedge CLK) disable iff (!RSTN)
		byte_done && (state == LCDI_DATA) && !sub_match
		|=> !ack_pend && !DATA_WE;
	endproperty
	a_data_nak: assert property (p_data_nak)
		else $error("Data acknowledged without subaddress match");

	property p_drive_ack;
		@(posedge CLK) disable iff (!RSTN)
		!SDA_OE_N |-> ack_on && (SDA_OUT == 1'b0);
	endproperty
	a_drive_ack: assert property (p_drive_ack)
		else $error("Data line driven outside acknowledge");

	property p_ack_hold;
		@(posedge CLK) disable iff (!RSTN)
		$fell(SDA_OE_N) ##1 !scl_fall [*3] |-> !SDA_OE_N;
	endproperty
	a_ack_hold: assert property (p_ack_hold)
		else $error("Acknowledge dropped before clock fell");
endmodule

/* testbench/lcdi_ctrl_model.sv */
/*
 * Behavioural two-wire bus controller facing the display driver target.
 * Assumes the bench resolves the data line with a pull-up from sda_drv
 * and the target's drive; serial clock is 48 ns and stands high idle.
 */
`timescale 1ns/1ps
module lcdi_ctrl_model
(
	output logic scl, // Serial clock, high between frames
	output logic sda_drv, // Data drive, 1 releases to pull-up
	input wire logic sda // Resolved data line
);
	initial
	begin
		scl = 1'h1;
		sda_drv = 1'h1;
	end
	task start;
		#1;
		sda_drv = 1'h1;
		#12 scl = 1'h1;
		#12 sda_drv = 1'h0;
		#24 scl = 1'h0;
		#12;
	endtask
	task stop;
		sda_drv = 1'h0;
		#12 scl = 1'h1;
		#12 sda_drv = 1'h1;
		#24;
	endtask
	// Data moves only while the clock is low
	task send(input logic [7:0] b, output logic ack);
		for (int i = 7; i >= 0; i--)
		begin
			sda_drv = b[i];
			#12 scl = 1'h1;
			#24 scl = 1'h0;
			#12;
		end
		sda_drv = 1'h1;
		#12 scl = 1'h1;
		// Low at both ends of the high phase
		#1 ack = ~sda;
		#22 ack = ack & ~sda;
		#1 scl = 1'h0;
		#12;
	endtask
endmodule

/* testbench/tb_lcdi_top.sv */
/*
 * Self-checking bench of the display driver's two-wire write target.
 * Assumes the controller model above and a pulled-up data line.
 */
`timescale 1ns/1ps
module tb_lcdi_top;
	import lcdi_pkg::*;
	logic clk = 1'h0;
	logic rst_n;
	logic strap = 1'h0;
	logic [1:0] hw_sub = 2'h0;
	logic ptr_ld = 1'h0;
	logic sub_ld = 1'h0;
	logic [4:0] ptr_v = 5'h00;
	logic [1:0] sub_v = 2'h0;
	wire scl;
	wire sda_drv;
	wire sda;
	logic sda_out;
	logic sda_oe_n;
	logic cmd_v;
	logic we;
	logic sel;
	logic [7:0] cmd_b;
	logic [7:0] dat_b;
	logic [4:0] dptr;
	logic [1:0] dsub;
	logic ack;
	int n_mismatch = 0;
	int n_compared = 0;
	int n_cmd = 0;
	int n_we = 0;
	always #2 clk = ~clk;
	// Pull-up wins unless someone pulls low
	assign sda = sda_drv & (sda_oe_n | sda_out);
	lcdi_ctrl_model m
	(
		.scl(scl),
		.sda_drv(sda_drv),
		.sda(sda)
	);
	lcdi_top uut
	(
		.CLK(clk),
		.RSTN(rst_n),
		.SCL(scl),
		.SDA_IN(sda),
		.SDA_OUT(sda_out),
		.SDA_OE_N(sda_oe_n),
		.ADDRESS_SELECT_STRAP(strap),
		.HW_SUBADDRESS_BIT_LO(hw_sub[0]),
		.HW_SUBADDRESS_BIT_HI(hw_sub[1]),
		.PTR_LOAD(ptr_ld),
		.PTR_VALUE(ptr_v),
		.SUB_LOAD(sub_ld),
		.SUB_VALUE(sub_v),
		.CMD_VALID(cmd_v),
		.CMD_BYTE(cmd_b),
		.DATA_WE(we),
		.DATA_BYTE(dat_b),
		.DATA_PTR(dptr),
		.DATA_SUBADDR(dsub),
		.SELECTED(sel)
	);
	always @(posedge clk)
	begin
		if (cmd_v === 1'h1)
			n_cmd++;
		if (we === 1'h1)
			n_we++;
	end
	task check(input string what, input logic [7:0] seen,
		input logic [7:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task test_done;
		$display("compared %0d mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task byte_ack(input logic [7:0] b, input logic exp);
		m.send(b, ack);
		check("ack", 8'(ack), 8'(exp));
	endtask
	task load(input logic [4:0] p, input logic [1:0] s);
		@(posedge clk);
		ptr_ld <= 1'h1;
		sub_ld <= 1'h1;
		ptr_v <= p;
		sub_v <= s;
		@(posedge clk);
		ptr_ld <= 1'h0;
		sub_ld <= 1'h0;
		// Serial edges must not land on a system clock edge
		#1;
	endtask
	task finish_frame;
		m.stop;
		repeat (8) @(posedge clk);
		check("sel", 8'(sel), 8'h00);
		check("oe", 8'(sda_oe_n), 8'h01);
		check("out", 8'(sda_out), 8'h00);
	endtask
	// Address, chained commands, two data bytes, stop
	task t_write;
		int c0;
		c0 = n_cmd;
		m.start;
		byte_ack(8'h70, 1'h1);
		check("sel", 8'(sel), 8'h01);
		byte_ack(8'h80, 1'h1);
		check("cmd", cmd_b, 8'h80);
		byte_ack(8'h00, 1'h1);
		check("ncmd", 8'(n_cmd - c0), 8'h02);
		byte_ack(8'hc4, 1'h1);
		check("data", dat_b, 8'hc4);
		check("ptr", 8'(dptr), 8'h00);
		byte_ack(8'h1e, 1'h1);
		check("data", dat_b, 8'h1e);
		check("ptr", 8'(dptr), 8'h01);
		check("nwe", 8'(n_we), 8'h02);
		finish_frame;
	endtask
	// Strap high: wrong address and read are both ignored
	task t_strap;
		int c0;
		@(posedge clk);
		strap <= 1'h1;
		repeat (4) @(posedge clk);
		c0 = n_cmd;
		m.start;
		byte_ack(8'h70, 1'h0);
		byte_ack(8'h80, 1'h0);
		check("ncmd", 8'(n_cmd - c0), 8'h00);
		m.start;
		byte_ack(8'h73, 1'h0);
		m.start;
		byte_ack(8'h72, 1'h1);
		byte_ack(8'h00, 1'h1);
		check("ncmd", 8'(n_cmd - c0), 8'h01);
		finish_frame;
	endtask
	// Subaddress gating and pointer wrap into counter
	task t_sub;
		int w0;
		@(posedge clk);
		hw_sub <= 2'h1;
		repeat (4) @(posedge clk);
		w0 = n_we;
		m.start;
		byte_ack(8'h72, 1'h1);
		byte_ack(8'h00, 1'h1);
		byte_ack(8'h55, 1'h0);
		check("nwe", 8'(n_we - w0), 8'h00);
		load(5'h1f, 2'h1);
		byte_ack(8'h69, 1'h1);
		check("ptr", 8'(dptr), 8'h1f);
		check("sub", 8'(dsub), 8'h01);
		byte_ack(8'h96, 1'h0);
		check("nwe", 8'(n_we - w0), 8'h01);
		m.start;
		byte_ack(8'h72, 1'h1);
		byte_ack(8'h00, 1'h1);
		finish_frame;
	endtask
	initial
	begin
		// A real falling edge also resets the serial-clock sampler
		rst_n <= 1'h0;
		repeat (4) @(posedge clk);
		rst_n <= 1'h1;
		repeat (4) @(posedge clk);
		t_write;
		t_strap;
		t_sub;
		test_done;
	end
	// Whole run needs about 8 us
	initial
	begin
		#100000;
		n_mismatch++;
		test_done;
	end
endmodule
